// file: pkg/zlps_pkg.sv
// shared constants and carriers of the pipelined sync memory port
package zlps_pkg;
   localparam int ADDR_W = 17;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int DEPTH = 131072;
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
   localparam int CTRL_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam int ST_SLEEP_BIT = 0;
   localparam int ST_ILV_BIT = 1;
   localparam int ST_ACTIVE_BIT = 2;
   localparam int ST_WRITE_BIT = 3;
   localparam int ST_BEAT_LSB = 4;
   localparam logic [1:0] BEAT_ONE = 2'h1;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic readNotWrite;
      logic advanceOrLoad;
      logic chipEnableN;
      logic expansionSelectN;
      logic expansionSelect;
      logic [LANES-1:0] byteWriteN;
   } zlps_pins_t;

   typedef struct packed {
      logic valid;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] byteWriteN;
   } zlps_cmd_t;
endpackage : zlps_pkg

// file: src/zlps_core.sv
// pipelined zero-turnaround memory port with apb control and status
//
// Functional notes
// - all synchronous pins land in input registers every enabled rising edge
// - array is 128K words of 36 bits in four lanes of 9 bits
// - a two-bit burst counter steps word addresses inside a burst
// - load cycle low two address bits seed the burst counter
// - advance_or_load low at an edge loads a new external address
// - advance_or_load high steps the burst and ignores read/write select
// - read or write is fixed at load and kept through the burst
// - read/write select low at load makes a write, timed by the clock
// - reads and writes may alternate every clock with no idle cycle
// - low byte write enables pick written lanes; other lanes keep contents
// - byte enables travel with their address and gate the later data
// - enable n controls lane n: a, b, c, d
// - primary chip enable is sampled only at load; deselect starts nothing
// - selected only with both low enables low and high enable high
// - output enable low turns data drivers on for valid read data, otherwise released
// - clock_gate_n high freezes every pipeline and burst state but the output enable register
// - read data leaves through an output register
// - burst addresses follow linear or interleaved order by mode pin
// - mode low is linear, high interleaved; not changed while running
// - sleep_request high keeps array, ignores all other inputs but the apb port
// - all byte enables low at load writes the full word
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module zlps_core (
   input wire logic clock,
   input wire logic rst_n,
   input zlps_pkg::zlps_pins_t pins,
   input wire logic clockGateN,
   input wire logic outputEnableN,
   input wire logic sleepRequest,
   input wire logic burstInterleave,
   input wire logic [zlps_pkg::DATA_W-1:0] dataIn,
   output logic [zlps_pkg::DATA_W-1:0] dataOut,
   output logic dataOe,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [zlps_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import zlps_pkg::*;

   logic [DATA_W-1:0] mem [DEPTH];

   logic oeN1_r, oeN2_r, sleep1_r, sleep2_r, mode1_r, mode2_r;
   logic step;
   zlps_pins_t in_r;
   logic [DATA_W-1:0] dataIn_r;
   logic active_r, op_r;
   logic [ADDR_W-1:0] base_r;
   logic [LANES-1:0] bw_r;
   logic [1:0] beat_r;
   zlps_cmd_t cmd_r, cmd_nxt, wr_r;
   logic [DATA_W-1:0] dataOut_r, rdWord;
   logic outValid_r, dataOe_r;
   logic [31:0] ctrl_r, prdata_r;
   logic pready_r, pslverr_r;
   logic loadSel, apbAcc;

   function automatic logic [DATA_W-1:0] laneMerge(
      input logic [DATA_W-1:0] oldW,
      input logic [DATA_W-1:0] newW,
      input logic [LANES-1:0] bwN
   );
      logic [DATA_W-1:0] res;
      res = oldW;
      for (int i = 0; i < LANES; i++) begin
         if (!bwN[i]) begin
            res[i*LANE_W +: LANE_W] = newW[i*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction : laneMerge

   function automatic logic [1:0] burstLow(
      input logic [1:0] seed,
      input logic [1:0] beat,
      input logic ilv
   );
      return ilv ? (seed ^ beat) : 2'(seed + beat);
   endfunction : burstLow

   // asynchronous pins through two flops
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         oeN1_r <= 1'b1;
         oeN2_r <= 1'b1;
         sleep1_r <= 1'b0;
         sleep2_r <= 1'b0;
         mode1_r <= 1'b1;
         mode2_r <= 1'b1;
      end else begin
         oeN1_r <= outputEnableN;
         oeN2_r <= oeN1_r;
         sleep1_r <= sleepRequest;
         sleep2_r <= sleep1_r;
         mode1_r <= burstInterleave;
         mode2_r <= mode1_r;
      end
   end

   assign step = !clockGateN && !sleep2_r;

   // input registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         in_r <= '0;
         in_r.advanceOrLoad <= 1'b1;
         in_r.chipEnableN <= 1'b1;
         in_r.byteWriteN <= '1;
         dataIn_r <= '0;
      end else if (step) begin
         in_r <= pins;
         dataIn_r <= dataIn;
      end
   end

   assign loadSel = !in_r.chipEnableN && !in_r.expansionSelectN
      && in_r.expansionSelect && ctrl_r[CTRL_EN_BIT];

   // load or burst advance
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         active_r <= 1'b0;
         op_r <= 1'b0;
         base_r <= '0;
         bw_r <= '1;
         beat_r <= '0;
      end else if (step) begin
         if (!in_r.advanceOrLoad) begin
            active_r <= loadSel;
            op_r <= !in_r.readNotWrite;
            base_r <= in_r.addr;
            bw_r <= in_r.byteWriteN;
            beat_r <= '0;
         end else if (active_r) begin
            beat_r <= beat_r + BEAT_ONE;
         end
      end
   end

   always_comb begin
      cmd_nxt = '0;
      if (!in_r.advanceOrLoad) begin
         cmd_nxt.valid = loadSel;
         cmd_nxt.wr = !in_r.readNotWrite;
         cmd_nxt.addr = in_r.addr;
         cmd_nxt.byteWriteN = in_r.byteWriteN;
      end else begin
         cmd_nxt.valid = active_r;
         cmd_nxt.wr = op_r;
         cmd_nxt.addr = {base_r[ADDR_W-1:2],
            burstLow(base_r[1:0], beat_r + BEAT_ONE, mode2_r)};
         cmd_nxt.byteWriteN = bw_r;
      end
   end

   // command and write stages
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cmd_r <= '0;
         wr_r <= '0;
      end else if (step) begin
         cmd_r <= cmd_nxt;
         wr_r <= cmd_r.wr ? cmd_r : '0;
      end
   end

   // array write, data sampled at the edge before
   always_ff @(posedge clock) begin
      if (step && wr_r.valid) begin
         mem[wr_r.addr] <= laneMerge(mem[wr_r.addr], dataIn_r,
            wr_r.byteWriteN);
      end
   end

   // bypass of the write landing on the same edge
   always_comb begin
      rdWord = mem[cmd_r.addr];
      if (wr_r.valid && wr_r.addr == cmd_r.addr) begin
         rdWord = laneMerge(rdWord, dataIn_r, wr_r.byteWriteN);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dataOut_r <= '0;
         outValid_r <= 1'b0;
      end else if (step) begin
         outValid_r <= cmd_r.valid && !cmd_r.wr;
         if (cmd_r.valid && !cmd_r.wr) begin
            dataOut_r <= rdWord;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dataOe_r <= 1'b0;
      end else begin
         dataOe_r <= !oeN2_r && !sleep2_r && outValid_r;
      end
   end

   assign dataOut = dataOut_r;
   assign dataOe = dataOe_r;

   // apb slave, one wait state
   assign apbAcc = psel && penable && !pready_r;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         prdata_r <= '0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= apbAcc;
         // write lands on the edge that completes the transfer
         if (psel && penable && pready_r && pwrite && paddr == OFS_CTRL) begin
            ctrl_r <= {31'h0, pwdata[CTRL_EN_BIT]};
         end
         pslverr_r <= 1'b0;
         prdata_r <= '0;
         if (apbAcc) begin
            unique case (paddr)
               OFS_CTRL: begin
                  if (!pwrite) begin
                     prdata_r <= ctrl_r;
                  end
               end
               OFS_STATUS: begin
                  prdata_r[ST_SLEEP_BIT] <= sleep2_r;
                  prdata_r[ST_ILV_BIT] <= mode2_r;
                  prdata_r[ST_ACTIVE_BIT] <= active_r;
                  prdata_r[ST_WRITE_BIT] <= op_r;
                  prdata_r[ST_BEAT_LSB +: 2] <= beat_r;
               end
               default: begin
                  pslverr_r <= 1'b1;
               end
            endcase
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // checks
   AST_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n)
      step |=> in_r == $past(pins) && dataIn_r == $past(dataIn))
      else $error("pins not captured");

   AST_DESELECT: assert property (@(posedge clock) disable iff (!rst_n)
      step && !in_r.advanceOrLoad && !loadSel |=> !cmd_r.valid && !active_r)
      else $error("deselected load started an access");

   AST_SELECT: assert property (@(posedge clock) disable iff (!rst_n)
      step && !in_r.advanceOrLoad && !in_r.chipEnableN
      && !in_r.expansionSelectN && in_r.expansionSelect
      && ctrl_r[CTRL_EN_BIT] |=> cmd_r.valid && beat_r == 2'h0)
      else $error("selected load did not start");

   AST_OP_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      step && in_r.advanceOrLoad |=> $stable(op_r) && $stable(base_r))
      else $error("access type changed during burst");

   AST_BEAT: assert property (@(posedge clock) disable iff (!rst_n)
      step && in_r.advanceOrLoad && active_r
      |=> beat_r == 2'($past(beat_r) + 2'h1))
      else $error("burst counter did not step");

   AST_LINEAR: assert property (@(posedge clock) disable iff (!rst_n)
      step && in_r.advanceOrLoad && active_r && !mode2_r |=> cmd_r.addr[1:0]
      == 2'($past(base_r[1:0]) + $past(beat_r) + 2'h1))
      else $error("linear burst address wrong");

   AST_STALL: assert property (@(posedge clock) disable iff (!rst_n)
      clockGateN |=> $stable(cmd_r) && $stable(beat_r) && $stable(dataOut_r))
      else $error("state moved while clock gated");

   AST_READ_LAT: assert property (@(posedge clock) disable iff (!rst_n)
      step && !in_r.advanceOrLoad && loadSel && in_r.readNotWrite
      ##1 step [*2] |-> outValid_r)
      else $error("read data not valid two edges after load");

   AST_OE: assert property (@(posedge clock) disable iff (!rst_n)
      dataOe_r |-> !$past(oeN2_r) && $past(outValid_r))
      else $error("drivers on without output enable");

   AST_SLEEP: assert property (@(posedge clock) disable iff (!rst_n)
      sleep2_r |=> $stable(in_r) && !dataOe_r)
      else $error("inputs taken during sleep");

   AST_LOAD_BASE: assert property (@(posedge clock) disable iff (!rst_n)
      step && !in_r.advanceOrLoad
      |=> base_r == $past(in_r.addr) && beat_r == 2'h0)
      else $error("load did not seed the burst");

   AST_UPPER: assert property (@(posedge clock) disable iff (!rst_n)
      step && in_r.advanceOrLoad && active_r
      |=> cmd_r.addr[ADDR_W-1:2] == $past(base_r[ADDR_W-1:2]))
      else $error("burst left its block");

   AST_INTERLEAVE: assert property (@(posedge clock) disable iff (!rst_n)
      step && in_r.advanceOrLoad && active_r && mode2_r |=> cmd_r.addr[1:0]
      == ($past(base_r[1:0]) ^ 2'($past(beat_r) + 2'h1)))
      else $error("interleaved burst address wrong");

   AST_ADV_IGNORE: assert property (@(posedge clock) disable iff (!rst_n)
      step && in_r.advanceOrLoad && active_r
      |=> cmd_r.valid && cmd_r.wr == $past(op_r))
      else $error("advance beat changed the access");

   AST_BW_CARRY: assert property (@(posedge clock) disable iff (!rst_n)
      step && !in_r.advanceOrLoad && loadSel
      |=> cmd_r.byteWriteN == $past(in_r.byteWriteN)
      && cmd_r.wr == !$past(in_r.readNotWrite))
      else $error("byte enables not kept with their address");

   AST_WRITE_STAGE: assert property (@(posedge clock) disable iff (!rst_n)
      step && cmd_r.valid && cmd_r.wr
      |=> wr_r.valid && wr_r.addr == $past(cmd_r.addr))
      else $error("write did not reach the write stage");

   AST_READ_NO_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
      step && !(cmd_r.valid && cmd_r.wr) |=> !wr_r.valid)
      else $error("array write without a write access");

   AST_OUT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      step && !(cmd_r.valid && !cmd_r.wr) |=> $stable(dataOut_r))
      else $error("read data moved without a read");

   AST_OE_OFF: assert property (@(posedge clock) disable iff (!rst_n)
      oeN2_r |=> !dataOe_r)
      else $error("drivers on with output enable high");

   AST_BURST_END: assert property (@(posedge clock) disable iff (!rst_n)
      step && !in_r.advanceOrLoad && !loadSel
      ##1 step && in_r.advanceOrLoad |=> !cmd_r.valid)
      else $error("advance after deselect started an access");

   AST_APB_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
      pready_r |=> !pready_r)
      else $error("ready held longer than one cycle");

   AST_APB_ERR: assert property (@(posedge clock) disable iff (!rst_n)
      pslverr_r |-> pready_r)
      else $error("error without ready");

   COV_DESELECT: cover property (@(posedge clock) disable iff (!rst_n)
      step && !in_r.advanceOrLoad && in_r.chipEnableN);

   COV_BURST: cover property (@(posedge clock) disable iff (!rst_n)
      step && active_r && beat_r == 2'h3);
   COV_TURN: cover property (@(posedge clock) disable iff (!rst_n)
      step && cmd_r.valid && cmd_r.wr ##1 step && cmd_r.valid && !cmd_r.wr);
   COV_STALL: cover property (@(posedge clock) disable iff (!rst_n)
      cmd_r.valid && clockGateN [*2]);
   COV_BYPASS: cover property (@(posedge clock) disable iff (!rst_n)
      step && wr_r.valid && cmd_r.valid && wr_r.addr == cmd_r.addr);
endmodule : zlps_core

// file: dv/zlps_ctl_model.sv
// controller model driving the memory port pins and write data
`timescale 1ns/100ps
module zlps_ctl_model
   import zlps_pkg::*;
(
   input wire logic clock,
   input wire logic clockGateN,
   output zlps_pkg::zlps_pins_t pins,
   output logic [zlps_pkg::DATA_W-1:0] dataIn,
   output logic rdMark
);
   logic on, rd, wNow, w1;
   logic [DATA_W-1:0] wdNow, wd1;
   initial begin
      pins = '0;
      pins.chipEnableN = 1'b1;
      {on, rd, wNow, w1, rdMark} = '0;
      {dataIn, wdNow, wd1} = '0;
   end
   task op(input logic adv, rnw, input logic [ADDR_W-1:0] a,
      input logic [LANES-1:0] bwn, input logic [2:0] en,
      input logic [DATA_W-1:0] wd);
      logic sel;
      sel = on;
      if (!adv) begin
         sel = en == 3'b001;
         rd = rnw;
      end
      on = sel;
      pins <= '{a, rnw, adv, en[2], en[1], en[0], bwn};
      rdMark <= sel & rd;
      wNow <= sel & !rd;
      wdNow <= wd;
      @(posedge clock);
   endtask : op
   // data follows its load by two enabled edges, pattern otherwise
   always @(posedge clock) if (!clockGateN) begin
      w1 <= wNow;
      wd1 <= wdNow;
      dataIn <= w1 ? wd1 : ~dataIn;
   end
endmodule : zlps_ctl_model

// file: dv/zero_latency_pipelined_sync_sram_bench.sv
// self-checking bench of the pipelined memory port
`timescale 1ns/100ps
module zero_latency_pipelined_sync_sram_bench;
   import zlps_pkg::*;
   logic clock = 0, rst_n = 0, clockGateN = 0, outputEnableN = 0;
   logic sleepRequest = 0, burstInterleave = 0;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdv;
   logic pready, pslverr, dataOe, rdMark, errv;
   zlps_pins_t pins;
   logic [DATA_W-1:0] dataIn, dataOut;
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] expQ [$];
   logic [3:0] pipe = '0;
   logic [ADDR_W-1:0] base;
   logic [63:0] r64;
   int seed = 53, error_cnt = 0, compares = 0;
   always #25 clock = ~clock;
   zlps_core dut (.clock(clock), .rst_n(rst_n), .pins(pins),
      .clockGateN(clockGateN), .outputEnableN(outputEnableN),
      .sleepRequest(sleepRequest), .burstInterleave(burstInterleave),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   zlps_ctl_model u_ctl (.clock(clock), .clockGateN(clockGateN),
      .pins(pins), .dataIn(dataIn), .rdMark(rdMark));
   task chk(input logic [DATA_W-1:0] got, exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task wrap_up;
      if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
      n, input logic [3:0] bwn);
      merge = o;
      for (int l = 0; l < LANES; l++)
         if (!bwn[l]) merge[l*LANE_W +: LANE_W] = n[l*LANE_W +: LANE_W];
   endfunction : merge
   task idle(input int n);
      repeat (n) u_ctl.op(1'b0, 1'b1, '0, 4'hF, 3'b100, '0);
   endtask : idle
   task apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
      idle(1);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // rnw and address are inverted on advance beats, which must ignore them
   task burst(input logic rnw, ilv, input int n, input logic [3:0] bwn);
      logic [ADDR_W-1:0] ad;
      for (int i = 0; i < n; i++) begin
         ad = base;
         ad[1:0] = ilv ? base[1:0] ^ i[1:0] : base[1:0] + i[1:0];
         r64 = {$random(seed), $random(seed)};
         if (rnw) expQ.push_back(mem[ad]);
         else mem[ad] = merge(mem[ad], r64[DATA_W-1:0], bwn);
         u_ctl.op(i != 0, rnw ^ (i != 0), (i == 0) ? base : ~base, bwn,
            3'b001, r64[DATA_W-1:0]);
      end
   endtask : burst
   // read results land two enabled edges after their load, checked one edge later
   always @(posedge clock) if (!rst_n) pipe <= '0;
   else if (!clockGateN) begin
      pipe <= {pipe[2:0], rdMark};
      if (pipe[2]) chk(dataOut, expQ.pop_front());
      if (pipe[3]) chk(dataOe, 1'b1);
   end
   initial begin
      repeat (2000) @(posedge clock);
      error_cnt++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      idle(3);
      apb(1'b0, OFS_CTRL, '0);
      chk(rdv, CTRL_RST);
      apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
      chk(errv, 1'b0);
      apb(1'b0, 8'h40, '0);
      chk(errv, 1'b1);
      r64 = {$random(seed), $random(seed)};
      base = {r64[ADDR_W-1:2], 2'h2};
      burst(1'b0, 1'b0, 4, 4'h0);
      burst(1'b1, 1'b0, 4, 4'h0);
      for (int l = 0; l < LANES; l++) begin
         burst(1'b0, 1'b0, 1, ~(4'h1 << l));
         burst(1'b1, 1'b0, 1, 4'h0);
      end
      idle(1);
      burstInterleave <= 1'b1;
      apb(1'b0, OFS_STATUS, '0);
      chk(rdv[ST_ILV_BIT], 1'b1);
      burst(1'b1, 1'b1, 4, 4'h0);
      for (int e = 0; e < 3; e++)
         u_ctl.op(1'b0, 1'b0, base, 4'h0, 3'b001 ^ (3'b100 >> e), '0);
      burst(1'b1, 1'b1, 1, 4'h0);
      apb(1'b1, OFS_CTRL, '0);
      u_ctl.op(1'b0, 1'b0, base, 4'h0, 3'b001, '0);
      apb(1'b1, OFS_CTRL, 32'h1);
      burst(1'b1, 1'b1, 1, 4'h0);
      idle(1);
      sleepRequest <= 1'b1;
      idle(4);
      u_ctl.op(1'b0, 1'b0, base, 4'h0, 3'b001, '0);
      idle(1);
      sleepRequest <= 1'b0;
      idle(4);
      burst(1'b1, 1'b1, 1, 4'h0);
      idle(1);
      clockGateN <= 1'b1;
      idle(3);
      clockGateN <= 1'b0;
      idle(6);
      outputEnableN <= 1'b1;
      idle(6);
      chk(dataOe, 1'b0);
      chk(DATA_W'(expQ.size()), '0);
      wrap_up();
   end
endmodule : zero_latency_pipelined_sync_sram_bench
